// File: rtl/cmst_pkg.sv
package cmst_pkg;

    // device modes as seen by the supervisor
    typedef enum logic [2:0] {
        DM_NORMAL,
        DM_STOP,
        DM_SLEEP,
        DM_RESTART,
        DM_FAILSAFE
    } cmst_dev_t;

    // transceiver modes, upper bit set for normal and receive only
    typedef enum logic [1:0] {
        TRX_OFF,
        TRX_WAKE,
        TRX_RXONLY,
        TRX_NORMAL
    } cmst_trx_t;

    // bus termination selection
    typedef enum logic [1:0] {
        TERM_FLOAT,
        TERM_GND,
        TERM_HALF,
        TERM_FIXED
    } cmst_term_t;

    // register bus
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;
    localparam logic [3:0]  CTRL_ADDR   = 4'h0;
    localparam logic [3:0]  STAT_ADDR   = 4'h4;

    // control register fields
    localparam int          CTRL_DEV_LSB = 0;
    localparam int          CTRL_TRX_LSB = 4;
    localparam int          CTRL_WDW_BIT = 8;
    localparam int          CTRL_WDE_BIT = 9;

    // status register fields
    localparam int          ST_WAKE_BIT  = 0;
    localparam int          ST_FAIL_BIT  = 1;
    localparam int          ST_UV_BIT    = 2;
    localparam int          ST_TXTO_BIT  = 3;
    localparam int          ST_WOKEN_BIT = 4;

    // reset values
    localparam cmst_dev_t   DEV_RST      = DM_NORMAL;
    localparam cmst_trx_t   TRX_RST      = TRX_OFF;

    // timing, times in microseconds
    localparam int          CLK_MHZ      = 20;
    localparam int          CNT_W        = 24;
    localparam int          TX_TO_US     = 2000;
    localparam int          BUS_TO_US    = 4000;
    localparam int          SILENCE_US   = 1000;
    localparam int          RESTART_US   = 100;
    localparam int          TX_TO_CYC_DEF   = TX_TO_US * CLK_MHZ;
    localparam int          BUS_TO_CYC_DEF  = BUS_TO_US * CLK_MHZ;
    localparam int          SILENCE_CYC_DEF = SILENCE_US * CLK_MHZ;
    localparam int          RESTART_CYC_DEF = RESTART_US * CLK_MHZ;

endpackage : cmst_pkg

// File: rtl/cmst_timer.sv
module cmst_timer
    import cmst_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             run_i,
    input  wire logic [CNT_W-1:0] limit_i,
    // status
    output logic                  expired_o
);

    logic [CNT_W-1:0] count;

    // counts oscillator cycles while run is held, saturates at limit
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            count <= '0;
        end else if (count != limit_i) begin
            count <= count + 1'b1;
        end
    end

    assign expired_o = run_i && (count == limit_i);

endmodule : cmst_timer

// File: rtl/cmst_ctrl.sv
// Our own choices: the placing of the registers and the strobed register port.
module cmst_ctrl
    import cmst_pkg::*;
#(
    parameter logic [CNT_W-1:0] TX_TO_CYC   = CNT_W'(TX_TO_CYC_DEF),
    parameter logic [CNT_W-1:0] BUS_TO_CYC  = CNT_W'(BUS_TO_CYC_DEF),
    parameter logic [CNT_W-1:0] SILENCE_CYC = CNT_W'(SILENCE_CYC_DEF),
    parameter logic [CNT_W-1:0] RESTART_CYC = CNT_W'(RESTART_CYC_DEF)
)
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // microcontroller pins
    input  wire logic              bus_transmit_in_i,
    output logic                   bus_receive_out_o,
    output logic                   interrupt_request_low_o,
    // analog front end
    input  wire logic              bus_dominant_i,
    input  wire logic              wake_pattern_i,
    input  wire logic              transceiver_supply_low_i,
    output logic                   tx_enable_o,
    output logic                   tx_dominant_o,
    output cmst_term_t             term_o,
    // device supervision
    output cmst_dev_t              device_mode_o,
    output logic                   watchdog_enable_o
);

    // input synchronisers: txd, bus dominant, wake, undervoltage
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       wake_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1  <= 4'h1;
            sync2  <= 4'h1;
            wake_d <= 1'b0;
        end else begin
            sync1  <= {transceiver_supply_low_i, wake_pattern_i, bus_dominant_i,
                       bus_transmit_in_i};
            sync2  <= sync1;
            wake_d <= sync2[2];
        end
    end

    logic txd_dom;
    logic bus_dom;
    logic wake_evt;
    logic uv_s;

    assign txd_dom  = !sync2[0];
    assign bus_dom  = sync2[1];
    assign wake_evt = sync2[2] && !wake_d;
    assign uv_s     = sync2[3];

    // state
    cmst_dev_t  dev;
    cmst_trx_t  trx;
    logic       woken;
    logic       wake_stat;
    logic       int_pend;
    logic       bus_fault;
    logic       uv_flag;
    logic       wd_on_wake;
    logic       wd_en;
    logic       silence_done;

    // register decode
    logic       ctrl_wr;
    logic       stat_wr;
    logic [2:0] wr_dev;
    cmst_trx_t  wr_trx;
    logic       wr_dev_ok;
    logic       rearm;

    assign ctrl_wr   = wr_i && (addr_i == CTRL_ADDR);
    assign stat_wr   = wr_i && (addr_i == STAT_ADDR);
    assign wr_dev    = wdata_i[CTRL_DEV_LSB +: 3];
    assign wr_trx    = cmst_trx_t'(wdata_i[CTRL_TRX_LSB +: 2]);
    assign wr_dev_ok = wr_dev <= 3'(DM_FAILSAFE);

    // wake accepted only when wake capable and armed
    logic wake_hit;
    assign wake_hit = wake_evt && (trx == TRX_WAKE) && !woken;

    // mode toggle or entry to a low power mode re-arms
    assign rearm = ctrl_wr && ((wr_trx != TRX_WAKE) ||
                   (wr_dev_ok && (wr_dev == 3'(DM_STOP) ||
                    wr_dev == 3'(DM_SLEEP) || wr_dev == 3'(DM_FAILSAFE))));

    // timers
    logic tx_exp;
    logic bus_exp;
    logic sil_exp;
    logic rst_exp;
    cmst_timer u_tx_timer (.clk_i(clk_i), .rst_i(rst_i), .limit_i(TX_TO_CYC),
        .run_i((trx == TRX_NORMAL) && txd_dom), .expired_o(tx_exp));
    // clamping filter longer than tx time-out by default
    cmst_timer u_bus_timer (.clk_i(clk_i), .rst_i(rst_i), .limit_i(BUS_TO_CYC),
        .run_i(trx[1] && bus_dom), .expired_o(bus_exp));
    cmst_timer u_sil_timer (.clk_i(clk_i), .rst_i(rst_i), .limit_i(SILENCE_CYC),
        .run_i((trx == TRX_WAKE) && !bus_dom), .expired_o(sil_exp));
    cmst_timer u_rst_timer (.clk_i(clk_i), .rst_i(rst_i), .limit_i(RESTART_CYC),
        .run_i(dev == DM_RESTART), .expired_o(rst_exp));

    // device mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev <= DEV_RST;
        end else if (wake_hit && (dev == DM_SLEEP || dev == DM_FAILSAFE)) begin
            dev <= DM_RESTART;
        end else if (dev == DM_RESTART && rst_exp) begin
            dev <= DM_NORMAL;
        end else if (ctrl_wr && wr_dev_ok) begin
            dev <= cmst_dev_t'(wr_dev);
        end
    end

    // transceiver mode, never touched by faults or wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trx <= TRX_RST;
        end else if (ctrl_wr && wr_dev_ok && wr_dev == 3'(DM_FAILSAFE)) begin
            trx <= TRX_WAKE;
        end else if (ctrl_wr) begin
            trx <= wr_trx;
        end
    end

    // wake latch, set wins over re-arm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            woken <= 1'b0;
        end else if (wake_hit) begin
            woken <= 1'b1;
        end else if (rearm) begin
            woken <= 1'b0;
        end
    end

    // wake status and interrupt, cleared by writing one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_stat <= 1'b0;
        end else if (wake_hit) begin
            wake_stat <= 1'b1;
        end else if (stat_wr && wdata_i[ST_WAKE_BIT]) begin
            wake_stat <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_pend <= 1'b0;
        end else if (wake_hit && (dev == DM_NORMAL || dev == DM_STOP)) begin
            int_pend <= 1'b1;
        end else if (stat_wr && wdata_i[ST_WAKE_BIT]) begin
            int_pend <= 1'b0;
        end
    end

    // bus fault from tx time-out or clamping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_fault <= 1'b0;
        end else if (tx_exp || bus_exp) begin
            bus_fault <= 1'b1;
        end else if (stat_wr && wdata_i[ST_FAIL_BIT]) begin
            bus_fault <= 1'b0;
        end
    end

    // undervoltage flag, monitored only with upper mode bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_flag <= 1'b0;
        end else if (uv_s && trx[1]) begin
            uv_flag <= 1'b1;
        end else if (stat_wr && wdata_i[ST_UV_BIT]) begin
            uv_flag <= 1'b0;
        end
    end

    // watchdog control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_on_wake <= 1'b0;
        end else if (ctrl_wr) begin
            wd_on_wake <= wdata_i[CTRL_WDW_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_en <= 1'b0;
        end else if (wake_hit && dev == DM_STOP && wd_on_wake) begin
            wd_en <= 1'b1;
        end else if (ctrl_wr) begin
            wd_en <= wdata_i[CTRL_WDE_BIT];
        end
    end

    // silence qualification for ground termination
    always_ff @(posedge clk_i) begin
        if (rst_i || trx != TRX_WAKE) begin
            silence_done <= 1'b0;
        end else if (sil_exp) begin
            silence_done <= 1'b1;
        end
    end

    // termination selection
    cmst_term_t next_term;
    always_comb begin
        case (trx)
            TRX_OFF: next_term = TERM_FLOAT;
            TRX_WAKE: begin
                if (woken) begin
                    next_term = TERM_FIXED;
                end else if (silence_done) begin
                    next_term = TERM_GND;
                end else begin
                    next_term = TERM_FLOAT;
                end
            end
            TRX_RXONLY: next_term = uv_s ? TERM_FIXED : TERM_HALF;
            TRX_NORMAL: next_term = TERM_HALF;
            default:    next_term = TERM_FLOAT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_o <= TERM_FLOAT;
        end else begin
            term_o <= next_term;
        end
    end

    // transmitter drive, released again when cause removed
    logic next_tx_en;
    assign next_tx_en = (trx == TRX_NORMAL) && !tx_exp && !uv_s;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_enable_o   <= 1'b0;
            tx_dominant_o <= 1'b0;
        end else begin
            tx_enable_o   <= next_tx_en;
            tx_dominant_o <= next_tx_en && txd_dom;
        end
    end

    // receive output low once woken in wake capable mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_receive_out_o <= 1'b1;
        end else if (trx == TRX_WAKE) begin
            bus_receive_out_o <= !woken;
        end else if (trx[1]) begin
            bus_receive_out_o <= !bus_dom;
        end else begin
            bus_receive_out_o <= 1'b1;
        end
    end

    assign interrupt_request_low_o = !int_pend;
    assign device_mode_o           = dev;
    assign watchdog_enable_o       = wd_en;

    // read port, data valid only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        rdata_o <= '0;
        if (!rst_i && rd_i && addr_i == CTRL_ADDR) begin
            rdata_o[CTRL_DEV_LSB +: 3] <= dev;
            rdata_o[CTRL_TRX_LSB +: 2] <= trx;
            rdata_o[CTRL_WDW_BIT]      <= wd_on_wake;
            rdata_o[CTRL_WDE_BIT]      <= wd_en;
        end else if (!rst_i && rd_i && addr_i == STAT_ADDR) begin
            rdata_o[ST_WAKE_BIT]  <= wake_stat;
            rdata_o[ST_FAIL_BIT]  <= bus_fault;
            rdata_o[ST_UV_BIT]    <= uv_flag;
            rdata_o[ST_TXTO_BIT]  <= tx_exp;
            rdata_o[ST_WOKEN_BIT] <= woken;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_wake_int;
        wake_hit && (dev == DM_NORMAL || dev == DM_STOP)
            |=> !interrupt_request_low_o && wake_stat;
    endproperty
    a_wake_int: assert property (p_wake_int) else $error("wake interrupt missing");
    property p_wake_rx;
        (wake_hit ##1 (trx == TRX_WAKE)) |=> !bus_receive_out_o;
    endproperty
    a_wake_rx: assert property (p_wake_rx) else $error("receive not low after wake");
    property p_stop_stays;
        wake_hit && dev == DM_STOP && !wr_i |=> dev == DM_STOP;
    endproperty
    a_stop_stays: assert property (p_stop_stays) else $error("left stop on wake");
    property p_wd_wake;
        wake_hit && dev == DM_STOP && wd_on_wake |=> watchdog_enable_o;
    endproperty
    a_wd_wake: assert property (p_wd_wake) else $error("watchdog not enabled");
    property p_sleep_restart;
        wake_hit && dev == DM_SLEEP |=> dev == DM_RESTART;
    endproperty
    a_sleep_restart: assert property (p_sleep_restart) else $error("no restart");
    property p_no_int_sleep;
        wake_hit && dev == DM_SLEEP && interrupt_request_low_o |=> interrupt_request_low_o;
    endproperty
    a_no_int_sleep: assert property (p_no_int_sleep) else $error("interrupt on sleep");
    property p_tx_to;
        tx_exp |=> !tx_enable_o && !tx_dominant_o && bus_fault;
    endproperty
    a_tx_to: assert property (p_tx_to) else $error("transmitter not disabled");
    property p_clamp;
        bus_exp && !wr_i |=> bus_fault && $stable(trx);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamping not flagged");
    property p_off_float;
        trx == TRX_OFF |=> term_o == TERM_FLOAT;
    endproperty
    a_off_float: assert property (p_off_float) else $error("termination in off");
    property p_uv;
        uv_s && trx[1] |=> uv_flag && !tx_enable_o;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not handled");

endmodule : cmst_ctrl

// File: dv/cmst_mcu_model.sv
module cmst_mcu_model
    import cmst_pkg::*;
(
    // clock
    input  wire logic              clk_i,
    // register port
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] wdata_o,
    output logic                   wr_o,
    output logic                   rd_o,
    input  wire logic [DATA_W-1:0] rdata_i,
    // transceiver pins
    output logic                   txd_o,
    input  wire logic              rxd_i
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        addr_o  = 4'h0;
        wdata_o = 32'h0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        txd_o   = 1'b1;
    end

    // one-cycle write, lines scrambled when released
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr

    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd

    // wait for the low receive pin, then fetch the wake source
    task automatic wake_service(output logic [DATA_W-1:0] st);
        int n;
        n = 0;
        while (rxd_i !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        rd(STAT_ADDR, st);
    endtask : wake_service

    task automatic drive_txd(input logic v);
        @(posedge clk_i);
        txd_o <= v;
    endtask : drive_txd

endmodule : cmst_mcu_model

// File: dv/tb_can_transceiver_mode_supervision.sv
module tb_can_transceiver_mode_supervision;
    import cmst_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [CNT_W-1:0] TXC = 24'h8;
    localparam logic [CNT_W-1:0] BSC = 24'h10;
    localparam logic [CNT_W-1:0] SIL = 24'h8;
    localparam logic [CNT_W-1:0] RSC = 24'h10;

    logic              clk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr;
    logic              rd;
    logic              txd;
    logic              rxd;
    logic              int_req_n;
    logic              clamp;
    logic              wake;
    logic              uv;
    logic              tx_en;
    logic              tx_dom;
    logic              wd_en;
    cmst_term_t        term;
    cmst_dev_t         dev;
    int                fails;
    int                samples_checked;
    int                cycles;

    // bus level: own driver or an outside clamp
    wire logic bus_dom = tx_dom | clamp;

    cmst_ctrl #(.TX_TO_CYC(TXC), .BUS_TO_CYC(BSC), .SILENCE_CYC(SIL), .RESTART_CYC(RSC)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .bus_transmit_in_i(txd), .bus_receive_out_o(rxd),
        .interrupt_request_low_o(int_req_n), .bus_dominant_i(bus_dom),
        .wake_pattern_i(wake), .transceiver_supply_low_i(uv), .tx_enable_o(tx_en),
        .tx_dominant_o(tx_dom), .term_o(term), .device_mode_o(dev),
        .watchdog_enable_o(wd_en));

    cmst_mcu_model mcu (
        .clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata), .txd_o(txd), .rxd_i(rxd));

    always #25 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string n, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    function automatic logic [DATA_W-1:0] ctrl(input cmst_dev_t d, input cmst_trx_t t,
                                               input logic w);
        ctrl = DATA_W'(d) << CTRL_DEV_LSB | DATA_W'(t) << CTRL_TRX_LSB
             | DATA_W'(w) << CTRL_WDW_BIT;
    endfunction : ctrl

    task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        mcu.rd(a, d);
        chk_word(n, e, d & m);
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    task automatic pulse_wake;
        @(posedge clk_i);
        wake <= 1'b1;
        repeat (3) @(posedge clk_i);
        wake <= 1'b0;
    endtask : pulse_wake

    task automatic t_reset;
        chk_bit("rxd", 1'b1, rxd);
        chk_bit("irq", 1'b1, int_req_n);
        chk_bit("tx_en", 1'b0, tx_en);
        chk_word("term", 32'(TERM_FLOAT), 32'(term));
        rd_chk("trx", CTRL_ADDR, 32'h0000_0030, 32'h0);
        rd_chk("unmapped", 4'h8, 32'hFFFF_FFFF, 32'h0);
        pulse_wake();
        wait_cyc(6);
        chk_bit("rxd off", 1'b1, rxd);
        rd_chk("wake off", STAT_ADDR, 32'h0000_0011, 32'h0);
        mcu.wr(CTRL_ADDR, 32'h0000_0007);
        wait_cyc(1);
        chk_word("dev refused", 32'(DM_NORMAL), 32'(dev));
        $display("t_reset done");
    endtask : t_reset

    task automatic t_wake(input cmst_dev_t d, input logic irq_e, input cmst_dev_t dev_e);
        logic [DATA_W-1:0] st;
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_OFF, 1'b0));
        mcu.wr(STAT_ADDR, 32'h0000_0007);
        mcu.wr(CTRL_ADDR, ctrl(d, TRX_WAKE, 1'b1));
        wait_cyc(1);
        chk_word("term early", 32'(TERM_FLOAT), 32'(term));
        wait_cyc(SIL + 2);
        chk_word("term gnd", 32'(TERM_GND), 32'(term));
        chk_bit("rxd armed", 1'b1, rxd);
        pulse_wake();
        mcu.wake_service(st);
        chk_bit("rxd wake", 1'b0, rxd);
        chk_bit("irq", irq_e, int_req_n);
        chk_word("mode", 32'(dev_e), 32'(dev));
        chk_bit("wd", d == DM_STOP, wd_en);
        chk_word("term fixed", 32'(TERM_FIXED), 32'(term));
        chk_word("wake st", 32'h0000_0011, st & 32'h0000_0011);
        rd_chk("trx kept", CTRL_ADDR, 32'h0000_0030, 32'h0000_0010);
        if (dev_e == DM_RESTART) begin
            wait_cyc(RSC + 2);
            chk_word("restart end", 32'(DM_NORMAL), 32'(dev));
        end
        mcu.wr(STAT_ADDR, 32'h0000_0001);
        pulse_wake();
        wait_cyc(6);
        chk_bit("irq no rearm", 1'b1, int_req_n);
        if (d == DM_STOP) begin
            mcu.wr(CTRL_ADDR, ctrl(DM_STOP, TRX_WAKE, 1'b0));
            pulse_wake();
            wait_cyc(6);
            chk_bit("irq rearm", 1'b0, int_req_n);
            mcu.wr(STAT_ADDR, 32'h0000_0001);
        end
        $display("t_wake done");
    endtask : t_wake

    task automatic t_txto;
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_NORMAL, 1'b0));
        mcu.wr(STAT_ADDR, 32'h0000_0007);
        wait_cyc(3);
        chk_bit("tx_en", 1'b1, tx_en);
        chk_word("term half", 32'(TERM_HALF), 32'(term));
        mcu.drive_txd(1'b0);
        wait_cyc(4);
        chk_bit("tx_dom", 1'b1, tx_dom);
        wait_cyc(TXC);
        chk_bit("tx_en to", 1'b0, tx_en);
        chk_bit("tx_dom to", 1'b0, tx_dom);
        rd_chk("fault", STAT_ADDR, 32'h0000_000A, 32'h0000_000A);
        rd_chk("trx", CTRL_ADDR, 32'h0000_0030, 32'h0000_0030);
        mcu.drive_txd(1'b1);
        wait_cyc(4);
        chk_bit("tx_en back", 1'b1, tx_en);
        rd_chk("to live", STAT_ADDR, 32'h0000_0008, 32'h0);
        $display("t_txto done");
    endtask : t_txto

    task automatic t_clamp;
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_RXONLY, 1'b0));
        mcu.wr(STAT_ADDR, 32'h0000_0007);
        @(posedge clk_i);
        clamp <= 1'b1;
        repeat (BSC - 4) @(posedge clk_i);
        clamp <= 1'b0;
        rd_chk("short clamp", STAT_ADDR, 32'h0000_0002, 32'h0);
        @(posedge clk_i);
        clamp <= 1'b1;
        wait_cyc(BSC + 4);
        rd_chk("clamp", STAT_ADDR, 32'h0000_0002, 32'h0000_0002);
        rd_chk("trx", CTRL_ADDR, 32'h0000_0030, 32'h0000_0020);
        @(posedge clk_i);
        clamp <= 1'b0;
        $display("t_clamp done");
    endtask : t_clamp

    task automatic t_uv;
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_WAKE, 1'b0));
        mcu.wr(STAT_ADDR, 32'h0000_0007);
        @(posedge clk_i);
        uv <= 1'b1;
        wait_cyc(6);
        rd_chk("uv wake", STAT_ADDR, 32'h0000_0004, 32'h0);
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_RXONLY, 1'b0));
        wait_cyc(4);
        chk_word("term uv", 32'(TERM_FIXED), 32'(term));
        rd_chk("uv flag", STAT_ADDR, 32'h0000_0004, 32'h0000_0004);
        mcu.wr(CTRL_ADDR, ctrl(DM_NORMAL, TRX_NORMAL, 1'b0));
        wait_cyc(3);
        chk_bit("tx_en uv", 1'b0, tx_en);
        @(posedge clk_i);
        uv <= 1'b0;
        wait_cyc(5);
        chk_bit("tx_en ok", 1'b1, tx_en);
        chk_word("term ok", 32'(TERM_HALF), 32'(term));
        $display("t_uv done");
    endtask : t_uv

    initial begin
        clk_i           = 1'b0;
        rst_i           = 1'b1;
        wake            = 1'b0;
        uv              = 1'b0;
        clamp           = 1'b0;
        fails           = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_cyc(1);
        t_reset();
        t_wake(DM_NORMAL, 1'b0, DM_NORMAL);
        t_wake(DM_STOP, 1'b0, DM_STOP);
        t_wake(DM_SLEEP, 1'b1, DM_RESTART);
        t_wake(DM_FAILSAFE, 1'b1, DM_RESTART);
        t_wake(DM_RESTART, 1'b1, DM_NORMAL);
        t_txto();
        t_clamp();
        t_uv();
        stop_test();
    end

endmodule : tb_can_transceiver_mode_supervision
